//--- logic/mad_decoder.sv
// data memory address decoder top
`timescale 1ns/1ps
`default_nettype none
module mad_decoder
    import mad_pkg::*;
#(
    parameter logic [1:0] SIZE_SEL  = MAD_SIZE_16K,
    parameter bit         AUX_512   = 1'b1
)(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // program status word from core
    input  wire logic [7:0] i_program_status_word,
    // data access request
    input  wire logic       i_req,
    input  wire mad_kind_e  i_kind,
    input  wire logic [7:0] i_addr,
    input  wire logic [2:0] i_reg_num,
    input  wire logic [7:0] i_r0_val,
    input  wire logic [7:0] i_r1_val,
    // program/aux requests
    input  wire logic       i_code_read,
    input  wire logic       i_aux_access,
    input  wire logic       i_aux_write,
    input  wire logic       i_flash_write_en,
    input  wire logic [13:0] i_code_addr,
    // stack control
    input  wire logic       i_push,
    input  wire logic       i_sp_load,
    input  wire logic [7:0] i_sp_load_val,
    // decoded data access
    output logic            o_valid,
    output mad_tgt_e        o_target,
    output logic [7:0]      o_byte_addr,
    output logic [2:0]      o_bit_pos,
    output logic            o_bit_access,
    // program/aux decode
    output logic            o_flash_read,
    output logic            o_flash_write,
    output logic            o_aux_ram_sel,
    output logic            o_lock_byte_hit,
    // stack
    output logic [7:0]      o_stack_top_pointer,
    output logic [7:0]      o_push_addr
);
    mad_stack_if stk ();

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // above 0x7F only the addressing mode tells the two spaces apart
    function automatic mad_tgt_e route_hi(input logic hi);
        return hi ? MAD_T_SPEC : MAD_T_IRAM;
    endfunction

    // the lock byte is the last byte of whichever flash size is fitted
    function automatic logic [13:0] lock_of(input logic [1:0] sel);
        logic [13:0] a;
        case (sel)
            MAD_SIZE_16K: a = MAD_LOCK_16K;
            MAD_SIZE_8K:  a = MAD_LOCK_8K;
            default:      a = MAD_LOCK_4K;
        endcase
        return a;
    endfunction

    // bytes below 0x80 hold the low bit space, above it x0/x8 registers
    function automatic logic [7:0] bit_home(input logic [7:0] a);
        return a[7] ? {a[7:3], 3'h0} : (MAD_BIT_BASE + {4'h0, a[6:3]});
    endfunction

    // ----------------------------------------
    // register banks
    // ----------------------------------------
    logic       bank_select_low;
    logic       bank_select_high;
    logic [7:0] bank_base;
    logic [7:0] reg_addr;
    logic [7:0] ind_addr;
    logic [7:0] bit_byte;
    logic [1:0] bank_sel;
    assign bank_select_low  = i_program_status_word[MAD_BANK_LO_BIT];
    assign bank_select_high = i_program_status_word[MAD_BANK_HI_BIT];
    assign bank_sel         = {bank_select_high, bank_select_low};
    assign bank_base = {3'h0, bank_sel, 3'h0};
    assign reg_addr  = bank_base | {5'h00, i_reg_num};
    // r0/r1 hold a full address, so no bank base is added
    // index from r0 or r1
    assign ind_addr  = i_reg_num[0] ? i_r1_val : i_r0_val;

    // ----------------------------------------
    // bit address split
    // ----------------------------------------
    // low bit addresses in 0x20-0x2F
    // high ones pick x0/x8 special register
    assign bit_byte = bit_home(i_addr);
    // the ram merges the bit itself; only its position travels on

    // ----------------------------------------
    // target selection
    // ----------------------------------------
    logic       upper;
    mad_tgt_e   tgt_d;
    logic [7:0] addr_d;
    assign upper = i_addr >= MAD_UPPER_BASE;

    always_comb begin
        tgt_d  = MAD_T_NONE;
        addr_d = 8'h00;
        // operand type picks bit or byte
        case (i_kind)
            MAD_K_DIRECT: begin
                tgt_d  = route_hi(upper);
                addr_d = i_addr;
            end
            MAD_K_INDIRECT: begin
                tgt_d  = MAD_T_IRAM;
                addr_d = ind_addr;
            end
            MAD_K_REGISTER: begin
                // register kind ignores the address field
                tgt_d  = MAD_T_IRAM;
                addr_d = reg_addr;
            end
            MAD_K_BIT: begin
                tgt_d  = route_hi(upper);
                addr_d = bit_byte;
            end
            default: begin
                tgt_d  = MAD_T_NONE;
                addr_d = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // request qualification
    // ----------------------------------------
    mad_tgt_e   tgt_sel;
    logic       bit_sel;
    // a refused request leaves every target deselected
    assign tgt_sel = i_req ? tgt_d : MAD_T_NONE;
    assign bit_sel = i_req && (i_kind == MAD_K_BIT);

    // ----------------------------------------
    // program memory and aux decode
    // ----------------------------------------
    logic [13:0] lock_addr;
    logic        lock_hit;
    logic        fl_rd;
    logic        fl_wr;
    logic        aux_sel;
    logic        to_flash;
    assign lock_addr = lock_of(SIZE_SEL);
    assign lock_hit  = i_code_read && (i_code_addr == lock_addr);
    // code read is the only flash read path
    assign fl_rd     = i_code_read;
    // reads stay on aux ram even while flash writing is armed
    assign to_flash  = i_aux_write && i_flash_write_en;
    assign fl_wr     = i_aux_access && to_flash;
    // aux ram exists only on 512-byte parts
    assign aux_sel   = i_aux_access && !to_flash && AUX_512;

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // one cycle of latency keeps outputs glitch free toward the rams
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_valid         <= 1'b0;
            o_target        <= MAD_T_NONE;
            o_byte_addr     <= 8'h00;
            o_bit_pos       <= 3'h0;
            o_bit_access    <= 1'b0;
        end else begin
            o_valid         <= i_req;
            o_target        <= tgt_sel;
            o_byte_addr     <= addr_d;
            o_bit_pos       <= i_addr[2:0];
            o_bit_access    <= bit_sel;
        end
    end

    // program and aux strobes share the same one-cycle delay
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flash_read    <= 1'b0;
            o_flash_write   <= 1'b0;
            o_aux_ram_sel   <= 1'b0;
            o_lock_byte_hit <= 1'b0;
        end else begin
            o_flash_read    <= fl_rd;
            o_flash_write   <= fl_wr;
            o_aux_ram_sel   <= aux_sel;
            o_lock_byte_hit <= lock_hit;
        end
    end

    // ----------------------------------------
    // stack pointer
    // ----------------------------------------
    assign stk.push     = i_push;
    assign stk.load     = i_sp_load;
    assign stk.load_val = i_sp_load_val;
    assign o_stack_top_pointer = stk.sp;
    // push address is combinational so the core writes in the push cycle
    assign o_push_addr         = stk.push_addr;

    mad_stack_ptr u_sp (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .stk     (stk.unit)
    );
endmodule
`default_nettype wire

//--- logic/mad_pkg.sv
// constants and types for the data memory address decoder
// Functional notes
// - program and data spaces selected by instruction
// - last code byte is the lock byte
// - flash read by code fetch; aux writes may program
// - 512-byte parts: upper 256 in aux ram
// - lower 128 bytes direct or indirect
// - upper 128 indirect only, separate storage
// - above 0x7F: direct special, indirect ram
// - 0x00-0x1F hold four banks of eight
// - status bits 3 and 4 pick bank
// - bank n maps to n times eight
// - indirect address from r0 or r1
// - bytes 0x20-0x2F hold 128 bit addresses
// - high bit addresses hit x0/x8 special registers
// - bit or byte chosen by operand type
// - push writes pointer plus one, then increments
// - reset loads pointer with 0x07
// - stack anywhere in 256 bytes
`default_nettype none
package mad_pkg;
    localparam logic [7:0]  MAD_SP_RESET     = 8'h07;
    localparam logic [7:0]  MAD_UPPER_BASE   = 8'h80;
    localparam logic [7:0]  MAD_BIT_BASE     = 8'h20;
    localparam logic [7:0]  MAD_ONE          = 8'h01;
    localparam int          MAD_BANK_LO_BIT  = 3;
    localparam int          MAD_BANK_HI_BIT  = 4;
    localparam logic [13:0] MAD_LOCK_16K     = 14'h3FFF;
    localparam logic [13:0] MAD_LOCK_8K      = 14'h1FFF;
    localparam logic [13:0] MAD_LOCK_4K      = 14'h0FFF;
    localparam logic [1:0]  MAD_SIZE_16K     = 2'h0;
    localparam logic [1:0]  MAD_SIZE_8K      = 2'h1;

    // data space access kind; one-hot
    typedef enum logic [3:0] {
        MAD_K_DIRECT   = 4'h1,
        MAD_K_INDIRECT = 4'h2,
        MAD_K_REGISTER = 4'h4,
        MAD_K_BIT      = 4'h8
    } mad_kind_e;

    // data memory target
    typedef enum logic [3:0] {
        MAD_T_NONE  = 4'h1,
        MAD_T_IRAM  = 4'h2,
        MAD_T_SPEC  = 4'h4,
        MAD_T_AUX   = 4'h8
    } mad_tgt_e;
endpackage
`default_nettype wire

//--- logic/mad_stack_if.sv
// interface between the decoder and the stack pointer unit
`timescale 1ns/1ps
`default_nettype none
interface mad_stack_if;
    logic       push;
    logic       load;
    logic [7:0] load_val;
    logic [7:0] sp;
    logic [7:0] push_addr;
    modport unit (input push, load, load_val, output sp, push_addr);
    modport user (output push, load, load_val, input sp, push_addr);
endinterface
`default_nettype wire

//--- logic/mad_stack_ptr.sv
// stack top pointer register
`timescale 1ns/1ps
`default_nettype none
module mad_stack_ptr
    import mad_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // control
    mad_stack_if.unit stk
);
    logic [7:0] stack_top_pointer_q;
    logic [7:0] stack_top_pointer_d;
    logic [7:0] next_ptr;

    assign next_ptr            = stack_top_pointer_q + MAD_ONE;
    assign stk.push_addr       = next_ptr;
    assign stk.sp              = stack_top_pointer_q;
    assign stack_top_pointer_d = stk.load ? stk.load_val :
                                 stk.push ? next_ptr : stack_top_pointer_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stack_top_pointer_q <= MAD_SP_RESET;
        end else begin
            stack_top_pointer_q <= stack_top_pointer_d;
        end
    end
endmodule
`default_nettype wire

//--- test/mad_core_model.sv
// core-side model supplying the active bank's index registers
`timescale 1ns/1ps
`default_nettype none
module mad_core_model (
    // status word from the core
    input  wire logic [7:0] i_program_status_word,
    // index registers of the active bank
    output logic      [7:0] o_r0_val,
    output logic      [7:0] o_r1_val
);
    // ----
    // index registers
    // ----
    // r0 and r1 of the active bank
    // values cross 0x7F per bank, so a wrong bank or register shows
    assign o_r0_val = {i_program_status_word[4:3], 6'h15};
    assign o_r1_val = ~o_r0_val;
endmodule
`default_nettype wire

//--- test/mad_decoder_bench.sv
// self-checking bench for the data memory address decoder
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_bench;
    import mad_pkg::*;
    // ----
    // stimulus and checks
    // ----
    logic        i_clk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0, i_push = 1'b0, rp, rl;
    logic        i_sp_load = 1'b0, i_code_read = 1'b0, i_aux_access = 1'b0;
    logic        i_aux_write = 1'b0, i_flash_write_en = 1'b0;
    logic [7:0]  i_program_status_word = 8'h00, i_addr = 8'h00, i_sp_load_val = 8'h00;
    logic [7:0]  i_r0_val, i_r1_val, o_byte_addr, o_stack_top_pointer, o_push_addr, rv, esp;
    logic [2:0]  i_reg_num = 3'h0, o_bit_pos;
    logic [13:0] i_code_addr = 14'h0000;
    logic        o_valid, o_bit_access, o_flash_read, o_flash_write, o_aux_ram_sel;
    logic        o_lock_byte_hit;
    mad_kind_e   i_kind = MAD_K_DIRECT;
    mad_tgt_e    o_target;
    int          mismatches = 0, n_compared = 0;
    mad_decoder dut (.*);
    mad_core_model core (.i_program_status_word(i_program_status_word),
        .o_r0_val(i_r0_val), .o_r1_val(i_r1_val));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] exp_adr(mad_kind_e k, logic [7:0] a, logic [2:0] n);
        case (k)
            MAD_K_INDIRECT: return n[0] ? i_r1_val : i_r0_val;
            MAD_K_REGISTER: return {3'h0, i_program_status_word[4:3], n};
            MAD_K_BIT:      return a[7] ? {a[7:3], 3'h0} : 8'h20 + 8'(a[6:3]);
            default:        return a;
        endcase
    endfunction
    task automatic go(input mad_kind_e k, input logic [7:0] a, input logic [2:0] n);
        logic [7:0] ea;
        logic       sp;
        @(posedge i_clk);
        i_req <= 1'b1;
        i_kind <= k;
        i_addr <= a;
        i_reg_num <= n;
        ea = exp_adr(k, a, n);
        sp = a[7] && (k == MAD_K_DIRECT || k == MAD_K_BIT);
        @(posedge i_clk);
        i_req <= 1'b0;
        #1;
        chk(o_byte_addr, ea);
        chk(8'(o_target), sp ? 8'(MAD_T_SPEC) : 8'(MAD_T_IRAM));
        chk(8'(o_bit_access), 8'(k == MAD_K_BIT));
    endtask
    task automatic prog(input logic w, input logic en, input logic [13:0] ca);
        @(posedge i_clk);
        i_aux_access <= 1'b1;
        i_aux_write <= w;
        i_flash_write_en <= en;
        i_code_read <= 1'b1;
        i_code_addr <= ca;
        @(posedge i_clk);
        i_aux_access <= 1'b0;
        i_code_read <= 1'b0;
        #1;
        chk(8'(o_flash_write), 8'(w && en));
        chk(8'(o_aux_ram_sel), 8'(!(w && en)));
        chk(8'(o_flash_read), 8'h01);
        chk(8'(o_lock_byte_hit), 8'(ca == MAD_LOCK_16K));
    endtask
    task automatic stk(input logic [7:0] v);
        @(posedge i_clk);
        i_sp_load <= 1'b1;
        i_sp_load_val <= v;
        @(posedge i_clk);
        i_sp_load <= 1'b0;
        i_push <= 1'b1;
        @(posedge i_clk);
        i_push <= 1'b0;
        #1;
        chk(o_stack_top_pointer, v + 8'h01);
        chk(o_push_addr, v + 8'h02);
    endtask
    initial begin
        void'($urandom(37));
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        chk(o_stack_top_pointer, MAD_SP_RESET);
        chk(o_push_addr, 8'h08);
        for (int b = 0; b < 4; b++) begin
            @(posedge i_clk);
            i_program_status_word <= 8'(b << 3);
            go(MAD_K_REGISTER, 8'hFF, 3'h7);
            go(MAD_K_INDIRECT, 8'h00, 3'(b));
        end
        go(MAD_K_DIRECT, 8'h7F, 3'h0);
        go(MAD_K_DIRECT, 8'h80, 3'h0);
        go(MAD_K_BIT, 8'h13, 3'h0);
        go(MAD_K_BIT, 8'hD7, 3'h0);
        $display("test decode done");
        prog(1'b0, 1'b0, MAD_LOCK_16K);
        prog(1'b1, 1'b0, 14'h3FFE);
        prog(1'b0, 1'b1, 14'h0FFF);
        prog(1'b1, 1'b1, 14'h1FFF);
        $display("test program done");
        stk(8'h5F);
        stk(8'hFF);
        $display("test stack done");
        // back-to-back random traffic; pointer wraps through loads and pushes
        esp = 8'h00;
        for (int c = 0; c < 400; c++) begin
            @(posedge i_clk);
            rp = 1'($urandom);
            rl = 1'(($urandom % 16) == 0);
            rv = 8'($urandom);
            esp = rl ? rv : esp + 8'(rp);
            i_push <= rp;
            i_sp_load <= rl;
            i_sp_load_val <= rv;
            i_req <= 1'($urandom);
            i_kind <= mad_kind_e'(4'h1 << ($urandom % 4));
            i_addr <= 8'($urandom);
            i_reg_num <= 3'($urandom);
            i_program_status_word <= 8'($urandom);
            i_code_read <= 1'($urandom);
            i_code_addr <= 14'($urandom) | 14'h3FF0;
            i_aux_access <= 1'($urandom);
            i_aux_write <= 1'($urandom);
            i_flash_write_en <= 1'($urandom);
        end
        @(posedge i_clk);
        i_push <= 1'b0;
        i_sp_load <= 1'b0;
        #1;
        chk(o_stack_top_pointer, esp);
        $display("test random done");
        results();
    end
endmodule
`default_nettype wire

//--- test/mad_decoder_monitor.sv
// assertion checker on the decoder top ports
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_monitor
    import mad_pkg::*;
#(
    parameter logic [1:0] SIZE_SEL = MAD_SIZE_16K,
    parameter bit         AUX_512  = 1'b1
)(
    // clock, reset and requests
    input wire logic        i_clk, i_rst_b, i_req, i_code_read, i_push, i_sp_load,
    input wire logic        i_aux_access, i_aux_write, i_flash_write_en,
    input wire mad_kind_e   i_kind,
    input wire logic [7:0]  i_program_status_word, i_addr, i_r0_val, i_r1_val,
    input wire logic [2:0]  i_reg_num,
    input wire logic [13:0] i_code_addr,
    // decoded outputs
    input wire logic        o_valid, o_bit_access, o_flash_read, o_lock_byte_hit,
    input wire logic        o_flash_write, o_aux_ram_sel,
    input wire mad_tgt_e    o_target,
    input wire logic [7:0]  o_byte_addr, o_stack_top_pointer, o_push_addr,
    input wire logic [2:0]  o_bit_pos
);
    // ----
    // properties
    // ----
    localparam logic [13:0] LOCK = (SIZE_SEL == MAD_SIZE_16K) ? MAD_LOCK_16K
        : (SIZE_SEL == MAD_SIZE_8K) ? MAD_LOCK_8K : MAD_LOCK_4K;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_take(k);
        i_req && i_kind == k;
    endsequence
    sequence s_push;
        i_push && !i_sp_load;
    endsequence
    chk_direct_route: assert property (
        s_take(MAD_K_DIRECT) |=> o_valid && o_byte_addr == $past(i_addr)
        && o_target == ($past(i_addr[7]) ? MAD_T_SPEC : MAD_T_IRAM)) else $error("direct bad");
    chk_indirect_ram: assert property (
        s_take(MAD_K_INDIRECT) |=> o_target == MAD_T_IRAM
        && o_byte_addr == ($past(i_reg_num[0]) ? $past(i_r1_val) : $past(i_r0_val)))
        else $error("indirect bad");
    chk_bank_map: assert property (
        s_take(MAD_K_REGISTER) |=> o_target == MAD_T_IRAM
        && o_byte_addr == {3'h0, $past(i_program_status_word[4:3]), $past(i_reg_num)})
        else $error("bank bad");
    chk_bit_map: assert property (
        s_take(MAD_K_BIT) |=> o_bit_access && o_bit_pos == $past(i_addr[2:0])
        && o_byte_addr == ($past(i_addr[7]) ? {$past(i_addr[7:3]), 3'h0}
        : 8'h20 + 8'($past(i_addr[6:3])))) else $error("bit bad");
    chk_byte_only: assert property (
        i_req && i_kind != MAD_K_BIT |=> !o_bit_access) else $error("byte as bit");
    chk_push_step: assert property (
        s_push |-> o_push_addr == o_stack_top_pointer + 8'h01
        ##1 o_stack_top_pointer == $past(o_push_addr)) else $error("push bad");
    chk_reset_ptr: assert property (
        $rose(i_rst_b) |-> o_stack_top_pointer == MAD_SP_RESET) else $error("reset bad");
    chk_lock_hit: assert property (
        i_code_read |=> o_flash_read && o_lock_byte_hit == ($past(i_code_addr) == LOCK))
        else $error("code bad");
    chk_aux_route: assert property (
        i_aux_access |=> o_flash_write == ($past(i_aux_write) && $past(i_flash_write_en))
        && o_aux_ram_sel == (AUX_512 && !($past(i_aux_write) && $past(i_flash_write_en))))
        else $error("aux bad");
    chk_aux_idle: assert property (
        !i_aux_access |=> !o_flash_write && !o_aux_ram_sel) else $error("aux idle bad");
    chk_idle_none: assert property (
        !i_req |=> !o_valid && o_target == MAD_T_NONE) else $error("idle bad");
endmodule
bind mad_decoder mad_decoder_monitor #(.SIZE_SEL(SIZE_SEL), .AUX_512(AUX_512)) u_monitor (.*);
`default_nettype wire
